// ==== rtl/stmh_pkg.sv ====
// Package of message codes, phases, actions and limits for the message handler.
package stmh_pkg;

    localparam logic [7:0] MSG_CMD_COMPLETE = 8'h00;
    localparam logic [7:0] MSG_INIT_ERR     = 8'h05;
    localparam logic [7:0] MSG_ABORT        = 8'h06;
    localparam logic [7:0] MSG_REJECT       = 8'h07;
    localparam logic [7:0] MSG_NOP          = 8'h08;
    localparam logic [7:0] MSG_PARITY_ERR   = 8'h09;
    localparam logic [7:0] MSG_DEV_RESET    = 8'h0C;
    localparam int         IDENT_BIT        = 7;
    localparam int         IDENT_PROC_BIT   = 5;
    localparam logic [3:0] SENSE_ABORTED    = 4'hB;
    localparam logic [3:0] SENSE_NONE       = 4'h0;
    localparam logic [1:0] MSGIN_RETRY_MAX  = 2'h3;
    localparam logic [1:0] RETRY_RST        = 2'h0;

    // Bus phase in which attention was seen.
    typedef enum logic [3:0] {
        PH_SELECTION = 4'h0,
        PH_COMMAND   = 4'h1,
        PH_DATA_OUT  = 4'h2,
        PH_DATA_IN   = 4'h3,
        PH_STATUS    = 4'h4,
        PH_MSG_OUT   = 4'h5,
        PH_MSG_IN    = 4'h6
    } stmh_phase_e;

    // Action ordered to the bus sequencer.
    typedef enum logic [3:0] {
        ACT_NONE        = 4'h0,
        ACT_BUS_FREE    = 4'h1,
        ACT_REDO_CMD    = 4'h2,
        ACT_REDO_DOUT   = 4'h3,
        ACT_RESEND_DIN  = 4'h4,
        ACT_CHECK_CC    = 4'h5,
        ACT_RESEND_STAT = 4'h6,
        ACT_RESEND_MSG  = 4'h7,
        ACT_SEND_REJECT = 4'h8,
        ACT_CHECK_COND  = 4'h9,
        ACT_MSG_OUT     = 4'hA,
        ACT_CONTINUE    = 4'hB
    } stmh_act_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_MOUT = 2'b10
    } stmh_state_e;

    // Context captured with each received message byte.
    typedef struct packed {
        logic [7:0]  code;
        stmh_phase_e phase;
        logic        image_xfer;
        logic        lun_known;
        logic        op_pending;
        logic        sent_reject;
        logic        sent_cmd_cmpl;
    } stmh_msg_s;

    // Result handed to the bus sequencer.
    typedef struct packed {
        stmh_act_e  act;
        logic       clr_own_op;
        logic       clr_all_ops;
        logic       unit_atten;
        logic       drop_rx;
        logic [3:0] sense_key;
    } stmh_res_s;

endpackage : stmh_pkg

// ==== rtl/stmh_msg_handler.sv ====
// Target-side decoder of initiator messages for a parallel SCSI target.
//
// How it works
// [R1] Code 05 means retry; the action depends on the attention phase.
// [R2] Code 05 after attention in selection goes bus free.
// [R3] Code 05 in command phase drops received CDB and redoes command.
// [R4] Code 05 in data-out drops received data and redoes data-out.
// [R5] Code 05 after image data-in: check condition, complete, free, key B.
// [R6] Code 05 after inquiry or sense data-in resends that data.
// [R7] Code 05 in status phase resends the status byte.
// [R8] Code 05 in message-in resends the same message byte.
// [R9] Code 06 clears the sender's operation then goes bus free.
// [R10] Abort before any identified unit only goes bus free.
// [R11] Abort with nothing pending raises no error.
// [R12] Initiators sharing the bus must reserve the unit first.
// [R13] Initiator raises no new attention before releasing acknowledge.
// [R14] Code 07 answering our reject gives check condition status.
// [R15] Initiator sends code 08 when it has nothing valid to send.
// [R16] Code 09 in message-in resends last message, else bus free.
// [R17] Message-in parity resends stop after three; then bus free.
// [R18] Code 0C resets all operations and sets unit attention for all.
// [R19] Initiator sends bus device reset asynchronously only.
// [R20] Codes 80 to FF identify; bit 5 set is answered with reject.
// [R21] Message-out is entered only after attention is asserted.
// [R22] Reject of command complete goes bus free.
// [R23] Unsupported codes get message reject and the sequence continues.
`timescale 1ns/1ps
module stmh_msg_handler
    import stmh_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        ce,
    input  wire logic        atn_pin,
    input  wire logic        phase_done,
    input  wire stmh_phase_e cur_phase,
    input  wire logic        msg_valid,
    input  wire stmh_msg_s   msg_in,
    input  wire logic        msgin_ok,
    output logic             res_valid_ff,
    output stmh_res_s        res_ff,
    output logic             lun_valid_ff,
    output logic [2:0]       lun_ff,
    output logic [1:0]       retry_cnt_ff
);

    stmh_state_e state_ff;
    stmh_state_e nxt_state;
    stmh_phase_e atn_phase_ff;
    logic [2:0]  atn_sync_ff;
    logic        atn_seen;
    logic        atn_ff;
    logic        take_msg;
    logic        go_mout;
    stmh_res_s   nxt_res;
    stmh_msg_s   m;
    logic [1:0]  nxt_retry;
    logic        retry_spent;

    // Attention comes from the bus pins; a level counts once the two late
    // stages agree, so a single metastable sample cannot flip it.
    assign atn_seen = atn_ff;

    // Attention is honoured only at a phase boundary.
    assign go_mout  = (state_ff == ST_IDLE) & atn_seen & phase_done; // [R21]
    assign take_msg = (state_ff == ST_MOUT) & msg_valid;
    assign m        = msg_in;

    function automatic stmh_res_s mk(input stmh_act_e a);
        stmh_res_s r;
        r           = '0;
        r.act       = a;
        r.sense_key = SENSE_NONE;
        return r;
    endfunction : mk

    assign retry_spent = (retry_cnt_ff == MSGIN_RETRY_MAX);

    always_comb begin
        nxt_res   = mk(ACT_NONE);
        nxt_retry = retry_cnt_ff;
        if (m.code[IDENT_BIT]) begin
            if (m.code[IDENT_PROC_BIT]) begin
                nxt_res = mk(ACT_SEND_REJECT); // [R20]
            end else begin
                nxt_res = mk(ACT_CONTINUE); // [R20]
            end
        end else begin
            case (m.code)
                MSG_INIT_ERR: begin
                    case (atn_phase_ff) // [R1]
                        PH_SELECTION: nxt_res = mk(ACT_BUS_FREE); // [R2]
                        PH_COMMAND: begin
                            nxt_res         = mk(ACT_REDO_CMD); // [R3]
                            nxt_res.drop_rx = 1'b1;
                        end
                        PH_DATA_OUT: begin
                            nxt_res         = mk(ACT_REDO_DOUT); // [R4]
                            nxt_res.drop_rx = 1'b1;
                        end
                        PH_DATA_IN: begin
                            if (m.image_xfer) begin
                                nxt_res           = mk(ACT_CHECK_CC); // [R5]
                                nxt_res.sense_key = SENSE_ABORTED;
                            end else begin
                                nxt_res = mk(ACT_RESEND_DIN); // [R6]
                            end
                        end
                        PH_STATUS:  nxt_res = mk(ACT_RESEND_STAT); // [R7]
                        PH_MSG_IN:  nxt_res = mk(ACT_RESEND_MSG); // [R8]
                        default:    nxt_res = mk(ACT_CONTINUE);
                    endcase
                end
                MSG_ABORT: begin
                    nxt_res = mk(ACT_BUS_FREE); // [R9]
                    // Nothing to clear is not an error; free the bus anyway.
                    nxt_res.clr_own_op = m.lun_known & m.op_pending; // [R10] [R11]
                end
                MSG_REJECT: begin
                    if (m.sent_reject) begin
                        nxt_res = mk(ACT_CHECK_COND); // [R14]
                    end else begin
                        nxt_res = mk(ACT_BUS_FREE); // [R22]
                    end
                end
                MSG_NOP: nxt_res = mk(ACT_CONTINUE);
                MSG_PARITY_ERR: begin
                    if (atn_phase_ff == PH_MSG_IN && !retry_spent) begin
                        nxt_res   = mk(ACT_RESEND_MSG); // [R16]
                        nxt_retry = retry_cnt_ff + 2'h1; // [R17]
                    end else begin
                        nxt_res = mk(ACT_BUS_FREE); // [R16] [R17]
                    end
                end
                MSG_DEV_RESET: begin
                    nxt_res             = mk(ACT_BUS_FREE);
                    nxt_res.clr_all_ops = 1'b1; // [R18]
                    nxt_res.unit_atten  = 1'b1; // [R18]
                end
                default: nxt_res = mk(ACT_SEND_REJECT); // [R23]
            endcase
        end
    end

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: if (go_mout) nxt_state = ST_MOUT;
            ST_MOUT: if (take_msg) nxt_state = ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            atn_sync_ff <= 3'h0;
            atn_ff      <= 1'b0;
        end else if (ce) begin
            atn_sync_ff <= {atn_sync_ff[1:0], atn_pin};
            if (atn_sync_ff[1] == atn_sync_ff[2]) begin
                atn_ff <= atn_sync_ff[2];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state_ff     <= ST_IDLE;
            atn_phase_ff <= PH_SELECTION;
            res_valid_ff <= 1'b0;
            res_ff       <= '0;
        end else if (ce) begin
            state_ff     <= nxt_state;
            res_valid_ff <= go_mout | take_msg;
            if (go_mout) begin
                atn_phase_ff <= cur_phase;
                res_ff       <= mk(ACT_MSG_OUT); // [R21]
            end else if (take_msg) begin
                res_ff <= nxt_res;
            end
        end
    end

    // Resend counter is cleared on msgin_ok while ce is high, unless a code 09 byte is taken in the same cycle.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            retry_cnt_ff <= RETRY_RST;
        end else if (ce) begin
            if (take_msg && m.code == MSG_PARITY_ERR) begin
                retry_cnt_ff <= nxt_retry; // [R17]
            end else if (msgin_ok) begin
                retry_cnt_ff <= RETRY_RST;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            lun_valid_ff <= 1'b0;
            lun_ff       <= 3'h0;
        end else if (ce) begin
            if (take_msg && m.code[IDENT_BIT]
                && !m.code[IDENT_PROC_BIT]) begin
                lun_valid_ff <= 1'b1; // [R20]
                lun_ff       <= m.code[2:0];
            end else if (take_msg && nxt_res.act == ACT_BUS_FREE) begin
                lun_valid_ff <= 1'b0;
            end
        end
    end

endmodule : stmh_msg_handler

// ==== testbench/stmh_host.sv ====
// Initiator model that raises attention and sends one message byte.
`timescale 1ns/1ps
module stmh_host
    import stmh_pkg::*;
(
    input  wire logic      clk_sys,
    input  wire logic      res_valid_ff,
    input  wire stmh_res_s res_ff,
    output logic           atn_pin,
    output logic           phase_done,
    output logic           msg_valid,
    output stmh_msg_s      msg_in
);
    initial begin
        atn_pin = 1'b0;
        phase_done = 1'b0;
        msg_valid = 1'b0;
        msg_in = '1;
    end
    // One initiator only, so operating without reservation is safe.
    // Every byte is a one-cycle msg_valid pulse, driven synchronously to clk_sys.
    task automatic send(input stmh_msg_s m);
        int n;
        atn_pin <= 1'b1;
        repeat (4) @(posedge clk_sys);
        phase_done <= 1'b1;
        @(posedge clk_sys);
        phase_done <= 1'b0;
        for (n = 0; n < 20; n++) begin
            if (res_valid_ff === 1'b1 && res_ff.act === ACT_MSG_OUT) break;
            @(posedge clk_sys);
        end
        atn_pin <= 1'b0;
        msg_valid <= 1'b1;
        msg_in <= m;
        @(posedge clk_sys);
        msg_valid <= 1'b0;
        msg_in <= ~m;
        repeat (2) @(posedge clk_sys);
    endtask : send
endmodule : stmh_host

// ==== testbench/stmh_msg_handler_checker.sv ====
// Concurrent checks on the message handler ports.
`timescale 1ns/1ps
module stmh_chk
    import stmh_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rstn,
    input wire logic        ce,
    input wire logic        atn_pin,
    input wire logic        phase_done,
    input wire stmh_phase_e cur_phase,
    input wire logic        msg_valid,
    input wire stmh_msg_s   msg_in,
    input wire logic        msgin_ok,
    input wire logic        res_valid_ff,
    input wire stmh_res_s   res_ff,
    input wire logic        lun_valid_ff,
    input wire logic [2:0]  lun_ff,
    input wire logic [1:0]  retry_cnt_ff
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    wire       c_got = msg_valid;
    wire [7:0] c     = msg_in.code;
    wire       e05   = c_got && c == MSG_INIT_ERR;
    wire       lk    = msg_in.lun_known;
    wire       own   = lk && msg_in.op_pending;
    chk_mout_after_atn: assert property (
        res_valid_ff && res_ff.act == ACT_MSG_OUT
        |-> $past(phase_done) && $past(atn_pin, 4)) else $error("early msg out");
    chk_sel_free: assert property (
        e05 && msg_in.phase == PH_SELECTION
        |=> res_valid_ff && res_ff.act == ACT_BUS_FREE) else $error("sel retry");
    chk_cmd_redo: assert property (
        e05 && msg_in.phase == PH_COMMAND
        |=> res_ff.act == ACT_REDO_CMD && res_ff.drop_rx) else $error("cmd redo");
    chk_dout_redo: assert property (
        e05 && msg_in.phase == PH_DATA_OUT
        |=> res_ff.act == ACT_REDO_DOUT && res_ff.drop_rx) else $error("dout");
    chk_image_abort: assert property (
        e05 && msg_in.phase == PH_DATA_IN && msg_in.image_xfer
        |=> res_ff.act == ACT_CHECK_CC && res_ff.sense_key == SENSE_ABORTED)
        else $error("image abort");
    chk_abort_clear: assert property (
        c_got && c == MSG_ABORT |=> res_ff.act == ACT_BUS_FREE
        && (res_ff.clr_own_op || !$past(own))
        && (!res_ff.clr_own_op || $past(lk))) else $error("abort clear");
    chk_dev_reset: assert property (
        c_got && c == MSG_DEV_RESET
        |=> res_valid_ff && res_ff.clr_all_ops && res_ff.unit_atten)
        else $error("device reset");
    chk_ident_rej: assert property (
        c_got && c[7] && c[5] |=> res_ff.act == ACT_SEND_REJECT)
        else $error("identify");
    chk_parity_limit: assert property (
        c_got && c == MSG_PARITY_ERR && msg_in.phase == PH_MSG_IN
        && retry_cnt_ff == MSGIN_RETRY_MAX |=> res_ff.act == ACT_BUS_FREE)
        else $error("parity limit");
    chk_reject_cc: assert property (
        c_got && c == MSG_REJECT && msg_in.sent_reject
        |=> res_ff.act == ACT_CHECK_COND) else $error("reject");
    cover property (res_valid_ff && res_ff.act == ACT_CHECK_CC);
    cover property (res_valid_ff && retry_cnt_ff == MSGIN_RETRY_MAX);
    cover property (lun_valid_ff);
endmodule : stmh_chk
bind stmh_msg_handler stmh_chk u_chk (.*);

// ==== testbench/testbench.sv ====
// Self-checking bench for the target message handler.
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[ERR] %0t mismatch got %h exp %h", $time, a, b); end end
module testbench;
    import stmh_pkg::*;
    logic        clk_sys = 1'b0, rstn = 1'b0, ce = 1'b1, msgin_ok = 1'b0;
    stmh_phase_e cur_phase = PH_SELECTION;
    logic        atn_pin, phase_done, msg_valid, res_valid_ff, lun_valid_ff;
    stmh_msg_s   msg_in;
    stmh_res_s   res_ff;
    logic [2:0]  lun_ff;
    logic [1:0]  retry_cnt_ff;
    int          n_mismatch = 0, tests_run = 0, i;
    logic [7:0]  q[$];
    logic [31:0] r;
    stmh_msg_handler dut (.*);
    stmh_host host (.*);
    initial forever #4 clk_sys = ~clk_sys;
    task stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : stop_test
    task run(input logic [7:0] cd, input stmh_phase_e ph, input logic [3:0] f,
             input stmh_act_e a);
        cur_phase <= ph;
        q.push_back({a, (cd == 8'h05 && ph == PH_DATA_IN && f[3]) ?
                     SENSE_ABORTED : SENSE_NONE});
        host.send('{cd, ph, f[3], f[2], f[1], f[0], 1'b0});
        $display("test of code %h done", cd);
    endtask : run
    task clr_retry;
        msgin_ok <= 1'b1;
        @(posedge clk_sys);
        msgin_ok <= 1'b0;
    endtask : clr_retry
    always @(posedge clk_sys) begin
        if (res_valid_ff === 1'b1 && res_ff.act !== ACT_MSG_OUT) begin
            if (q.size() == 0) `CHK(1'b1, 1'b0)
            else `CHK({res_ff.act, res_ff.sense_key}, q.pop_front())
        end
    end
    initial begin
        #200000;
        n_mismatch++;
        stop_test();
    end
    initial begin
        void'($urandom(32'h1ACA));
        r = $urandom;
        repeat (8) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        run(8'h05, PH_SELECTION, {2'h0, r[1:0]}, ACT_BUS_FREE);
        run(8'h05, PH_COMMAND, {2'h0, r[2:1]}, ACT_REDO_CMD);
        run(8'h05, PH_DATA_OUT, 4'h4, ACT_REDO_DOUT);
        run(8'h05, PH_DATA_IN, 4'hE, ACT_CHECK_CC);
        run(8'h05, PH_DATA_IN, 4'h6, ACT_RESEND_DIN);
        run(8'h05, PH_STATUS, 4'h0, ACT_RESEND_STAT);
        run(8'h05, PH_MSG_IN, 4'h4, ACT_RESEND_MSG);
        run(8'h05, PH_MSG_OUT, 4'h0, ACT_CONTINUE);
        run(8'h06, PH_COMMAND, 4'h6, ACT_BUS_FREE);
        run(8'h06, PH_SELECTION, 4'h0, ACT_BUS_FREE);
        run(8'h06, PH_DATA_OUT, 4'h4, ACT_BUS_FREE);
        run(8'h07, PH_MSG_IN, 4'h1, ACT_CHECK_COND);
        run(8'h07, PH_MSG_IN, 4'h0, ACT_BUS_FREE);
        run(8'h08, PH_COMMAND, 4'h0, ACT_CONTINUE);
        run(8'h0C, PH_DATA_IN, 4'h6, ACT_BUS_FREE);
        run(8'h00, PH_COMMAND, 4'h0, ACT_SEND_REJECT);
        run(8'h01, PH_STATUS, 4'h0, ACT_SEND_REJECT);
        clr_retry();
        for (i = 0; i < 3; i++) run(8'h09, PH_MSG_IN, 4'h4, ACT_RESEND_MSG);
        `CHK(retry_cnt_ff, MSGIN_RETRY_MAX)
        run(8'h09, PH_MSG_IN, 4'h4, ACT_BUS_FREE);
        clr_retry();
        run(8'h09, PH_MSG_IN, 4'h4, ACT_RESEND_MSG);
        run(8'h09, PH_STATUS, 4'h4, ACT_BUS_FREE);
        ce       <= 1'b0;
        msgin_ok <= 1'b1;
        repeat (2) @(posedge clk_sys);
        `CHK(retry_cnt_ff, 2'h1)
        ce       <= 1'b1;
        msgin_ok <= 1'b0;
        @(posedge clk_sys);
        run({3'b100, r[12:8]}, PH_SELECTION, 4'h0, ACT_CONTINUE);
        `CHK({lun_valid_ff, lun_ff}, {1'b1, r[10:8]})
        run({3'b101, r[20:16]}, PH_SELECTION, 4'h0, ACT_SEND_REJECT);
        `CHK(q.size(), 0)
        stop_test();
    end
endmodule : testbench
